// File: rtl/rtcr_consts.vh
/*
  constants for the rtc calendar and alarm register block.
  assumes inclusion by bare name from the rtl files.
*/
// Function
// - pad bit 1 set routes seconds clock to pin, clear routes alarm pulse.
// - clock pin drives only while the pin output enable bit is set.
// - time window pointer 00 minute_second_value, 10 month-day, 11 year.
// - alarm window pointer 01 weekday-hour, 10 month-day.
// - year is two bcd digits, tens 7:4, ones 3:0.
// - month tens bit 12 (0..1), ones bits 11:8.
// - day tens bits 5:4 (0..3), ones bits 3:0.
// - weekday is three bits at 10:8, values 0 to 6.
// - hour is 24-hour bcd, tens bits 5:4, ones bits 3:0.
// - minute tens bits 14:12, ones bits 11:8.
// - second tens bits 6:4, ones bits 3:0.
// - value writes take effect only while write enable is 1.
// - unimplemented bits read zero and ignore writes.
// - write to window high byte decrements pointer, stopping at 00.
// - any read of a value window decrements its pointer.
// - time pointer 01 weekday-hour; alarm pointer 11 selects nothing.
`ifndef RTCR_CONSTS_VH
`define RTCR_CONSTS_VH
// ----------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------
`define RTCR_A_CFG     4'h0
`define RTCR_A_PAD     4'h1
`define RTCR_A_ALCFG   4'h2
`define RTCR_A_TVAL    4'h3
`define RTCR_A_AVAL    4'h4
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RTCR_CFG_WREN  13
`define RTCR_CFG_OE    10
`define RTCR_PAD_SEC   1
`define RTCR_AL_EN     15
`define RTCR_AL_CHIME  14
`define RTCR_PTR_LO    8
// ----------------------------------------------------------------
// implemented-bit masks
// ----------------------------------------------------------------
`define RTCR_M_YEAR    16'h00ff
`define RTCR_M_MONTH_DAY_VALUE   16'h1f3f
`define RTCR_M_WKHR    16'h073f
`define RTCR_M_MINUTE_SECOND_VALUE  16'h7f7f
`define RTCR_M_PAD     16'h0003
`define RTCR_M_CFG     16'h2700
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RTCR_SEC_HZ    1
`define RTCR_CLK_HZ    100000000
`define RTCR_PULSE_CYC 16'h0064
`endif

// File: rtl/rtcr_window.v
/*
  one window register pair store with write mask and byte strobes.
  assumes write gating is decided by the caller.
*/
`timescale 1ns/1ns
`include "rtcr_consts.vh"
module rtcr_window #(
  parameter [15:0] MASK = 16'hffff
) (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        clk_en,
  input  wire        wr,
  input  wire [1:0]  be,
  input  wire [15:0] wdata,
  output reg  [15:0] value_q
);
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      value_q <= 16'h0000;
    end else if (clk_en && wr) begin
      if (be[0]) begin
        value_q[7:0] <= wdata[7:0] & MASK[7:0];
      end
      if (be[1]) begin
        value_q[15:8] <= wdata[15:8] & MASK[15:8];
      end
    end
  end
endmodule

// File: rtl/rtcr_ptr.v
/*
  two-bit window pointer: software load, decrement to 00 on access.
  assumes load and step are single-cycle strobes.
*/
`timescale 1ns/1ns
module rtcr_ptr (
  input  wire       sys_clk,
  input  wire       reset_n,
  input  wire       clk_en,
  input  wire       load,
  input  wire [1:0] load_val,
  input  wire       step,
  output reg  [1:0] ptr_q
);
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_q <= 2'h0;
    end else if (clk_en) begin
      if (load) begin
        ptr_q <= load_val;
      end else if (step && ptr_q != 2'h0) begin
        ptr_q <= ptr_q - 2'h1;
      end
    end
  end
endmodule

// File: rtl/rtcr_top.v
/*
  rtc calendar and alarm registers behind an avalon-mm slave.
  assumes a one-second tick input from the timekeeping logic,
  and that the master keeps the request until waitrequest is low.
*/
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "rtcr_consts.vh"
module rtcr_top (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        clk_en,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [1:0]  avs_byteenable,
  input  wire [15:0] avs_writedata,
  output reg  [15:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        second_tick,
  output reg         clock_pin_out,
  output reg         clock_pin_oe,
  output wire        parallel_port_buffer_select
);
  // ----------------------------------------------------------------
  // bus handshake: one wait cycle then acknowledge
  // ----------------------------------------------------------------
  reg         ack_q;
  wire        req;
  wire        acc;
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign acc = req & ack_q & clk_en;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else if (clk_en) begin
      ack_q <= req & ~ack_q;
    end
  end
  wire        wr_acc;
  wire        rd_acc;
  assign wr_acc = acc & avs_write;
  assign rd_acc = acc & avs_read;
  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  reg  [15:0] cfg_q;
  reg  [1:0]  pad_q;
  reg  [5:0]  alhi_q;
  reg  [7:0]  alarm_repeat_count_q;
  wire        value_write_enable;
  wire [3:0]  alarm_interval_mask;
  wire        seconds_output_select;
  wire        clock_pin_output_enable;
  wire        alarm_enable_bit;
  wire        chime;
  assign value_write_enable      = cfg_q[`RTCR_CFG_WREN];
  assign clock_pin_output_enable = cfg_q[`RTCR_CFG_OE];
  assign seconds_output_select   = pad_q[`RTCR_PAD_SEC];
  assign parallel_port_buffer_select = pad_q[0];
  assign alarm_enable_bit        = alhi_q[5];
  assign chime                   = alhi_q[4];
  assign alarm_interval_mask     = alhi_q[3:0];
  wire        wr_cfg;
  wire        wr_pad;
  wire        wr_al;
  wire        wr_tv;
  wire        wr_av;
  assign wr_cfg = wr_acc && avs_address == `RTCR_A_CFG;
  assign wr_pad = wr_acc && avs_address == `RTCR_A_PAD;
  assign wr_al  = wr_acc && avs_address == `RTCR_A_ALCFG;
  assign wr_tv  = wr_acc && avs_address == `RTCR_A_TVAL;
  assign wr_av  = wr_acc && avs_address == `RTCR_A_AVAL;
  wire        rd_tv;
  wire        rd_av;
  assign rd_tv = rd_acc && avs_address == `RTCR_A_TVAL;
  assign rd_av = rd_acc && avs_address == `RTCR_A_AVAL;
  // ----------------------------------------------------------------
  // alarm event and repeat logic
  // ----------------------------------------------------------------
  wire        alarm_event;
  reg  [15:0] pulse_cnt_q;
  wire [15:0] cfg_wmask;
  assign cfg_wmask = `RTCR_M_CFG;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q  <= 16'h0000;
      pad_q  <= 2'h0;
      alhi_q <= 6'h00;
      alarm_repeat_count_q <= 8'h00;
    end else if (clk_en) begin
      if (wr_cfg && avs_byteenable[1]) begin
        cfg_q[15:8] <= avs_writedata[15:8] & cfg_wmask[15:8];
      end
      if (wr_pad && avs_byteenable[0]) begin
        pad_q <= avs_writedata[1:0];
      end
      if (wr_al && avs_byteenable[0]) begin
        alarm_repeat_count_q <= avs_writedata[7:0];
      end else if (alarm_event) begin
        if (alarm_repeat_count_q != 8'h00 || chime) begin
          alarm_repeat_count_q <= alarm_repeat_count_q - 8'h01;
        end
      end
      if (wr_al && avs_byteenable[1]) begin
        alhi_q <= avs_writedata[15:10];
      end else if (alarm_event && alarm_repeat_count_q == 8'h00 && !chime) begin
        alhi_q[5] <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // window pointers
  // ----------------------------------------------------------------
  wire [1:0]  time_window_pointer;
  wire [1:0]  alarm_window_pointer;
  rtcr_ptr u_tptr (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .load     (wr_cfg & avs_byteenable[1]),
    .load_val (avs_writedata[9:8]),
    .step     ((wr_tv & avs_byteenable[1]) | rd_tv),
    .ptr_q    (time_window_pointer)
  );
  rtcr_ptr u_aptr (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .load     (wr_al & avs_byteenable[1]),
    .load_val (avs_writedata[9:8]),
    .step     ((wr_av & avs_byteenable[1]) | rd_av),
    .ptr_q    (alarm_window_pointer)
  );
  // ----------------------------------------------------------------
  // value registers, writes gated by write enable
  // ----------------------------------------------------------------
  wire        tw;
  wire        aw;
  assign tw = wr_tv & value_write_enable;
  assign aw = wr_av & value_write_enable;
  wire [15:0] year_value;
  wire [15:0] month_day_value;
  wire [15:0] weekday_hour_value;
  wire [15:0] minute_second_value;
  wire [15:0] alarm_month_day;
  wire [15:0] alarm_weekday_hour;
  wire [15:0] alarm_minute_second;
  // year: tens 7:4, ones 3:0
  rtcr_window #(.MASK(`RTCR_M_YEAR)) u_year (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .wr      (tw && time_window_pointer == 2'h3),
    .be      ({1'b0, avs_byteenable[0]}),
    .wdata   (avs_writedata),
    .value_q (year_value)
  );
  // month: tens bit 12 and ones 11:8 read only in time window, day tens 5:4
  rtcr_window #(.MASK(`RTCR_M_MONTH_DAY_VALUE)) u_month_day_value (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .wr      (tw && time_window_pointer == 2'h2),
    .be      ({1'b0, avs_byteenable[0]}),
    .wdata   (avs_writedata),
    .value_q (month_day_value)
  );
  rtcr_window #(.MASK(`RTCR_M_WKHR)) u_wkhr (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .wr      (tw && time_window_pointer == 2'h1),
    .be      (avs_byteenable),
    .wdata   (avs_writedata),
    .value_q (weekday_hour_value)
  );
  rtcr_window #(.MASK(`RTCR_M_MINUTE_SECOND_VALUE)) u_minute_second_value (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .wr      (tw && time_window_pointer == 2'h0),
    .be      (avs_byteenable),
    .wdata   (avs_writedata),
    .value_q (minute_second_value)
  );
  rtcr_window #(.MASK(`RTCR_M_MONTH_DAY_VALUE)) u_amthdy (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .wr      (aw && alarm_window_pointer == 2'h2),
    .be      (avs_byteenable),
    .wdata   (avs_writedata),
    .value_q (alarm_month_day)
  );
  rtcr_window #(.MASK(`RTCR_M_WKHR)) u_awkhr (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .wr      (aw && alarm_window_pointer == 2'h1),
    .be      (avs_byteenable),
    .wdata   (avs_writedata),
    .value_q (alarm_weekday_hour)
  );
  rtcr_window #(.MASK(`RTCR_M_MINUTE_SECOND_VALUE)) u_aminsec (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .wr      (aw && alarm_window_pointer == 2'h0),
    .be      (avs_byteenable),
    .wdata   (avs_writedata),
    .value_q (alarm_minute_second)
  );
  // ----------------------------------------------------------------
  // alarm compare with interval mask
  // ----------------------------------------------------------------
  reg         match;
  always @* begin
    case (alarm_interval_mask)
      4'h0: match = 1'b1;
      4'h1: match = 1'b1;
      4'h2: match = minute_second_value[3:0] == 4'h0;
      4'h3: match = minute_second_value[6:0] == alarm_minute_second[6:0];
      4'h4: match = minute_second_value[11:0] == alarm_minute_second[11:0];
      4'h5: match = minute_second_value == alarm_minute_second;
      4'h6: match = minute_second_value == alarm_minute_second &&
                    weekday_hour_value[5:0] == alarm_weekday_hour[5:0];
      4'h7: match = minute_second_value == alarm_minute_second &&
                    weekday_hour_value == alarm_weekday_hour;
      4'h8: match = minute_second_value == alarm_minute_second &&
                    weekday_hour_value[5:0] == alarm_weekday_hour[5:0] &&
                    month_day_value[5:0] == alarm_month_day[5:0];
      4'h9: match = minute_second_value == alarm_minute_second &&
                    weekday_hour_value[5:0] == alarm_weekday_hour[5:0] &&
                    month_day_value == alarm_month_day;
      default: match = 1'b0;
    endcase
  end
  assign alarm_event = alarm_enable_bit & second_tick & match;
  // ----------------------------------------------------------------
  // clock pin: seconds square wave or alarm pulse
  // ----------------------------------------------------------------
  reg         sec_q;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sec_q         <= 1'b0;
      pulse_cnt_q   <= 16'h0000;
      clock_pin_out <= 1'b0;
      clock_pin_oe  <= 1'b0;
    end else if (clk_en) begin
      if (second_tick) begin
        sec_q <= ~sec_q;
      end
      if (alarm_event) begin
        pulse_cnt_q <= `RTCR_PULSE_CYC;
      end else if (pulse_cnt_q != 16'h0000) begin
        pulse_cnt_q <= pulse_cnt_q - 16'h0001;
      end
      clock_pin_out <= seconds_output_select ? sec_q : (pulse_cnt_q != 16'h0000);
      clock_pin_oe  <= clock_pin_output_enable;
    end
  end
  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  reg  [15:0] rd_d;
  always @* begin
    rd_d = 16'h0000;
    if (avs_address == `RTCR_A_CFG) begin
      rd_d = {cfg_q[15:10], time_window_pointer, 8'h00};
    end else if (avs_address == `RTCR_A_PAD) begin
      rd_d = {14'h0000, pad_q};
    end else if (avs_address == `RTCR_A_ALCFG) begin
      rd_d = {alhi_q, alarm_window_pointer, alarm_repeat_count_q};
    end else if (avs_address == `RTCR_A_TVAL) begin
      case (time_window_pointer)
        2'h0: rd_d = minute_second_value;
        2'h1: rd_d = weekday_hour_value;
        2'h2: rd_d = month_day_value;
        default: rd_d = year_value;
      endcase
    end else if (avs_address == `RTCR_A_AVAL) begin
      case (alarm_window_pointer)
        2'h0: rd_d = alarm_minute_second;
        2'h1: rd_d = alarm_weekday_hour;
        2'h2: rd_d = alarm_month_day;
        default: rd_d = 16'h0000;
      endcase
    end
  end
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 16'h0000;
    end else if (clk_en && avs_read && !ack_q) begin
      avs_readdata <= rd_d;
    end
  end
endmodule

// File: tb/rtcr_top_monitor.sv
/* assertion checker for rtcr_top ports.
   assumes one wait state per access and clk_en held high. */
`timescale 1ns/1ns
`include "rtcr_consts.vh"
module rtcr_top_monitor (
  input wire        sys_clk,
  input wire        reset_n,
  input wire        clk_en,
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [1:0]  avs_byteenable,
  input wire [15:0] avs_writedata,
  input wire [15:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        second_tick,
  input wire        clock_pin_out,
  input wire        clock_pin_oe,
  input wire        parallel_port_buffer_select
);
  // ----
  // shadow pointers and pulse length
  // ----
  logic [1:0] tp_q;
  logic [1:0] ap_q;
  logic       sel_q;
  logic [7:0] hi_q;
  wire        acc = (avs_read | avs_write) & ~avs_waitrequest;
  wire        hwr = acc & avs_write & avs_byteenable[1];
  function automatic [15:0] wm(input [1:0] k);
    wm = k == 2'd0 ? `RTCR_M_MINUTE_SECOND_VALUE : k == 2'd1 ? `RTCR_M_WKHR :
         k == 2'd2 ? `RTCR_M_MONTH_DAY_VALUE : `RTCR_M_YEAR;
  endfunction
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tp_q  <= 2'b00;
      ap_q  <= 2'b00;
      sel_q <= 1'b0;
      hi_q  <= 8'h00;
    end else if (clk_en) begin
      hi_q <= clock_pin_out ? hi_q + 8'h01 : 8'h00;
      if (acc && avs_write && avs_address == 4'h1 && avs_byteenable[0])
        sel_q <= avs_writedata[1];
      if (hwr && avs_address == 4'h0)
        tp_q <= avs_writedata[9:8];
      else if (acc && avs_address == 4'h3 && (avs_read || hwr) && tp_q != 2'b00)
        tp_q <= tp_q - 2'b01;
      if (hwr && avs_address == 4'h2)
        ap_q <= avs_writedata[9:8];
      else if (acc && avs_address == 4'h4 && (avs_read || hwr) && ap_q != 2'b00)
        ap_q <= ap_q - 2'b01;
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd(logic [3:0] a);
    acc && avs_read && avs_address == a;
  endsequence
  sequence s_cfg_wr;
    hwr && avs_address == 4'h0;
  endsequence
  property p_wait_one;
    $rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait state count off");
  property p_pad_zero;
    s_rd(4'h1) |-> avs_readdata[15:2] == 14'h0000;
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("pad spare bits set");
  property p_unmapped;
    acc && avs_read && avs_address > 4'h4 |-> avs_readdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_tval_mask;
    s_rd(4'h3) |-> (avs_readdata & ~wm(tp_q)) == 16'h0000;
  endproperty
  a_tval_mask: assert property (p_tval_mask) else $error("time bits");
  property p_aval_mask;
    s_rd(4'h4) ##0 ap_q != 2'b11 |-> (avs_readdata & ~wm(ap_q)) == 16'h0000;
  endproperty
  a_aval_mask: assert property (p_aval_mask) else $error("alarm bits");
  property p_aval_none;
    s_rd(4'h4) ##0 ap_q == 2'b11 |-> avs_readdata == 16'h0000;
  endproperty
  a_aval_none: assert property (p_aval_none) else $error("alarm slot 3 not zero");
  property p_tptr;
    s_rd(4'h0) |-> avs_readdata[9:8] == tp_q;
  endproperty
  a_tptr: assert property (p_tptr) else $error("time pointer step");
  property p_aptr;
    s_rd(4'h2) |-> avs_readdata[9:8] == ap_q;
  endproperty
  a_aptr: assert property (p_aptr) else $error("alarm pointer step");
  property p_oe;
    s_cfg_wr |-> ##2 clock_pin_oe == $past(avs_writedata[10], 2);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable not taken");
  property p_pulse;
    $fell(clock_pin_out) && !sel_q |-> hi_q == `RTCR_PULSE_CYC;
  endproperty
  a_pulse: assert property (p_pulse) else $error("alarm pulse length");
endmodule
bind rtcr_top rtcr_top_monitor u_mon (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .second_tick(second_tick), .clock_pin_out(clock_pin_out),
  .clock_pin_oe(clock_pin_oe), .parallel_port_buffer_select(parallel_port_buffer_select));

// File: tb/tb_rtcr_top.sv
/* testbench for rtcr_top: random bcd values through both windows.
   assumes the one-wait-state avalon slave of rtcr_top. */
`timescale 1ns/1ns
`include "rtcr_consts.vh"
module tb_rtcr_top;
  // ----
  // stimulus and checks
  // ----
  reg         sys_clk = 1'b0;
  reg         reset_n = 1'b0;
  reg         clk_en = 1'b1;
  reg  [3:0]  avs_address = 4'h0;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [1:0]  avs_byteenable = 2'h0;
  reg  [15:0] avs_writedata = 16'h0000;
  reg         second_tick = 1'b0;
  wire [15:0] avs_readdata;
  wire        avs_waitrequest;
  wire        clock_pin_out;
  wire        clock_pin_oe;
  wire        ppb_sel;
  integer     seed = 32'haedf;
  integer     failures = 0;
  integer     checks_done = 0;
  integer     cyc = 0;
  integer     k, hi;
  reg  [15:0] q, v;
  reg  [15:0] tv [0:3];
  reg  [15:0] av [0:3];
  always #5 sys_clk = ~sys_clk;
  rtcr_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .second_tick(second_tick), .clock_pin_out(clock_pin_out),
    .clock_pin_oe(clock_pin_oe), .parallel_port_buffer_select(ppb_sel));
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task acc(input w, input [3:0] a, input [1:0] be, input [15:0] d);
    begin
      @(posedge sys_clk);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_byteenable <= be;
      avs_writedata <= d;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) begin
        @(posedge sys_clk);
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task tick;
    begin
      @(posedge sys_clk);
      second_tick <= 1'b1;
      @(posedge sys_clk);
      second_tick <= 1'b0;
      hi = 0;
      repeat (250) begin
        @(negedge sys_clk);
        if (clock_pin_out === 1'b1) hi = hi + 1;
      end
    end
  endtask
  function [15:0] msk(input integer k);
    msk = k == 0 ? `RTCR_M_MINUTE_SECOND_VALUE : k == 1 ? `RTCR_M_WKHR :
          k == 2 ? `RTCR_M_MONTH_DAY_VALUE : `RTCR_M_YEAR;
  endfunction
  function [15:0] dg(input integer m);
    dg = $unsigned($random(seed)) % m;
  endfunction
  function [15:0] bcd(input integer k);
    integer h;
    begin
      h = dg(24);
      case (k)
        0: bcd = dg(6) << 12 | dg(10) << 8 | dg(6) << 4 | dg(10);
        1: bcd = dg(7) << 8 | (h / 10) << 4 | h % 10;
        2: bcd = dg(2) << 12 | dg(10) << 8 | dg(4) << 4 | dg(10);
        default: bcd = dg(10) << 4 | dg(10);
      endcase
      bcd = bcd | ($random(seed) & ~msk(k));
    end
  endfunction
  task give_verdict;
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      give_verdict;
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    acc(1, 0, 3, 16'h2700);
    for (k = 3; k >= 0; k = k - 1) begin
      v = bcd(k);
      tv[k] = v & msk(k);
      acc(1, 3, 3, v);
      acc(0, 0, 3, 0);
      chk("time ptr", 16'h2400 | ((k > 0 ? k - 1 : 0) << 8), q);
    end
    acc(1, 0, 3, 16'h0700);
    acc(1, 3, 1, ~tv[3]);
    for (k = 3; k >= 0; k = k - 1) begin
      acc(0, 3, 3, 0);
      chk("time value", tv[k] & ~(k == 2 ? 16'h1f00 : 0), q & ~(k == 2 ? 16'h1f00 : 0));
    end
    acc(0, 3, 3, 0);
    chk("time stop", tv[0], q);
    $display("time window test done");
    acc(1, 0, 3, 16'h2400);
    chk("pin enable", 16'h0001, {15'h0, clock_pin_oe});
    acc(1, 2, 3, 16'h0200);
    for (k = 2; k >= 0; k = k - 1) begin
      v = bcd(k);
      av[k] = v & msk(k);
      acc(1, 4, 3, v);
    end
    acc(1, 2, 3, 16'h0300);
    acc(0, 4, 3, 0);
    chk("alarm slot 3", 16'h0000, q);
    for (k = 2; k >= 0; k = k - 1) begin
      acc(0, 4, 3, 0);
      chk("alarm value", av[k], q);
    end
    for (k = 5; k < 16; k = k + 1) begin
      acc(1, k, 3, $random(seed));
      acc(0, k, 3, 0);
      chk("unmapped", 16'h0000, q);
    end
    acc(1, 1, 3, 16'hffff);
    acc(0, 1, 3, 0);
    chk("pad", 16'h0003, q);
    chk("buffer select", 16'h0001, {15'h0, ppb_sel});
    acc(1, 1, 3, 16'h0000);
    $display("register map test done");
    acc(1, 2, 3, 16'h8001);
    tick;
    chk("alarm pulse", `RTCR_PULSE_CYC, hi);
    acc(0, 2, 3, 0);
    chk("repeat step", 16'h8000, q);
    tick;
    acc(0, 2, 3, 0);
    chk("alarm clear", 16'h0000, q);
    acc(1, 2, 3, 16'hc000);
    tick;
    acc(0, 2, 3, 0);
    chk("rollover", 16'hc0ff, q);
    acc(1, 2, 3, 16'ha800);
    tick;
    chk("reserved mask", 16'h0000, hi);
    acc(1, 1, 3, 16'h0002);
    tick;
    v[0] = clock_pin_out;
    tick;
    chk("seconds pin", {15'h0, ~v[0]}, {15'h0, clock_pin_out});
    acc(1, 0, 3, 16'h2000);
    repeat (2) @(posedge sys_clk);
    chk("pin disable", 16'h0000, {15'h0, clock_pin_oe});
    repeat (2) @(posedge sys_clk);
    $display("alarm and pin test done");
    give_verdict;
  end
endmodule
